// [rtl/pst_pkg.sv]
// Purpose: constants shared by the scan timer unit
// Assumes: 20 MHz clock, Avalon-MM register bus with 32-bit data
// Notes:   offsets are byte addresses of aligned words
`default_nettype none
package pst_pkg;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int unsigned CLOCK_HZ       = 20000000;
   localparam int unsigned FAST_TICK_MS   = 10;
   localparam int unsigned SLOW_TICK_MS   = 100;
   localparam int unsigned FAST_TICK_CYC  = CLOCK_HZ / 1000 * FAST_TICK_MS;
   localparam int unsigned SLOW_PER_FAST  = SLOW_TICK_MS / FAST_TICK_MS;
   // ----------------------------------------------------------------
   // limits, in counts of the timer's own resolution
   // ----------------------------------------------------------------
   localparam logic [31:0] SINGLE_MAX     = 32'h0000_270F; // 9999
   localparam logic [31:0] ACCUM_MAX      = 32'h05F5_E0FF; // 99999999
   localparam logic [31:0] CONST_PRESET_MAX = 32'h0000_270F;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [11:0] REG_CONTROL    = 12'h000; // enable, reset, mode per timer
   localparam logic [11:0] REG_STATUS_BITS= 12'h004; // done bits, read only
   localparam logic [11:0] REG_IRQ_STATUS = 12'h008; // sticky done rise, write 1 clear
   localparam logic [11:0] REG_IRQ_MASK   = 12'h00C;
   localparam logic [11:0] REG_SCAN       = 12'h010; // write: one scan evaluation
   localparam logic [11:0] REG_PRESET_BASE= 12'h100; // preset words, one per timer
   localparam logic [11:0] REG_WORD_BASE  = 12'h200; // data words, address = timer
   localparam logic [11:0] REG_VIEW_BASE  = 12'h300; // accumulated view by timer
   localparam logic [11:0] REG_BLOCK_MASK = 12'hF00;
   // control word fields per timer: 4 bits each
   localparam int unsigned CTL_EN         = 0;
   localparam int unsigned CTL_RST        = 1;
   localparam int unsigned CTL_FAST       = 2;
   localparam int unsigned CTL_ACCUM      = 3;
   localparam int unsigned CTL_STRIDE     = 4;
   // preset word fields
   localparam int unsigned PRE_FROM_WORD  = 31;
   localparam int unsigned PRE_SEL_LSB    = 24;
   localparam logic [31:0] PRE_VALUE_MASK = 32'h07FF_FFFF;
   localparam logic [31:0] READ_UNMAPPED  = 32'h0000_0000;
endpackage : pst_pkg
`default_nettype wire

// [rtl/pst_timer_unit.sv]
// Purpose: bank of ladder timers, single-input and accumulating
// Assumes: enables driven by the program through the control word
// Notes:   waitrequest low on a read one cycle after it is raised
//
// The Avalon-MM register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module pst_timer_unit #(
   parameter int unsigned NUM_TIMERS    = 8,
   parameter int unsigned FAST_TICK_CYC = pst_pkg::FAST_TICK_CYC
) (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic [11:0] avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output logic [NUM_TIMERS-1:0] timer_done,
   output logic             irq
);
   localparam int IW = $clog2(NUM_TIMERS);

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic [31:0] control;
   logic [31:0] preset  [NUM_TIMERS];
   logic [31:0] word    [NUM_TIMERS];
   logic [NUM_TIMERS-1:0] irq_status;
   logic [NUM_TIMERS-1:0] irq_mask;
   logic [31:0] fast_cnt;
   logic [3:0]  slow_cnt;
   logic        fast_tick;
   logic        slow_tick;
   logic        fast_pend;
   logic        slow_pend;
   logic        scan_req;
   logic        read_done;
   logic [NUM_TIMERS-1:0] next_done;

   // byte-lane merge of a write
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // address belongs to a per-timer block and names a live timer
   function automatic logic hit(input logic [11:0] a, input logic [11:0] base);
      return ((a & pst_pkg::REG_BLOCK_MASK) == base) && (a[1:0] == 2'h0)
             && (32'(a[7:2]) < NUM_TIMERS);
   endfunction : hit

   // effective preset of timer i
   function automatic logic [31:0] preset_of(input int i);
      logic [31:0] p;
      p = preset[i];
      if (p[pst_pkg::PRE_FROM_WORD]) begin
         return word[p[pst_pkg::PRE_SEL_LSB +: 3] % NUM_TIMERS];
      end
      if (!control[i*pst_pkg::CTL_STRIDE + pst_pkg::CTL_ACCUM]
          && (p & pst_pkg::PRE_VALUE_MASK) > pst_pkg::CONST_PRESET_MAX) begin
         return pst_pkg::CONST_PRESET_MAX; // constant clipped to 0..9999
      end
      return p & pst_pkg::PRE_VALUE_MASK;
   endfunction : preset_of

   wire logic [IW-1:0] sel = avs_address[IW+1:2];
   wire logic          wr  = avs_write;

   // ----------------------------------------------------------------
   // timebase: 10 ms tick and every tenth one as the 100 ms tick
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         fast_cnt <= 32'h0000_0000;
         slow_cnt <= 4'h0;
         fast_tick <= 1'b0;
         slow_tick <= 1'b0;
      end else begin
         fast_tick <= 1'b0;
         slow_tick <= 1'b0;
         if (fast_cnt == FAST_TICK_CYC - 1) begin
            fast_cnt  <= 32'h0000_0000;
            fast_tick <= 1'b1;
            if (32'(slow_cnt) == pst_pkg::SLOW_PER_FAST - 1) begin
               slow_cnt  <= 4'h0;
               slow_tick <= 1'b1;
            end else begin
               slow_cnt <= slow_cnt + 4'h1;
            end
         end else begin
            fast_cnt <= fast_cnt + 32'h0000_0001;
         end
      end
   end

   // ticks wait for the next scan so each scan applies at most one step
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         fast_pend <= 1'b0;
         slow_pend <= 1'b0;
      end else begin
         fast_pend <= fast_tick | (fast_pend & ~scan_req);
         slow_pend <= slow_tick | (slow_pend & ~scan_req);
      end
   end

   assign scan_req = wr && (avs_address == pst_pkg::REG_SCAN);

   // ----------------------------------------------------------------
   // control and presets written by software
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         control  <= 32'h0000_0000;
         irq_mask <= '0;
         for (int i = 0; i < NUM_TIMERS; i++) begin
            preset[i] <= 32'h0000_0000;
         end
      end else if (wr) begin
         if (avs_address == pst_pkg::REG_CONTROL) begin
            control <= merge(control, avs_writedata, avs_byteenable);
         end
         if (avs_address == pst_pkg::REG_IRQ_MASK) begin
            irq_mask <= avs_writedata[NUM_TIMERS-1:0];
         end
         if (hit(avs_address, pst_pkg::REG_PRESET_BASE)) begin
            preset[sel] <= merge(preset[sel], avs_writedata, avs_byteenable);
         end
      end
   end

   // ----------------------------------------------------------------
   // timer evaluation, one step per scan; value lives in word[i]
   // ----------------------------------------------------------------
   generate
      for (genvar g = 0; g < NUM_TIMERS; g++) begin : g_tmr
         wire logic en    = control[g*pst_pkg::CTL_STRIDE + pst_pkg::CTL_EN];
         wire logic rst   = control[g*pst_pkg::CTL_STRIDE + pst_pkg::CTL_RST];
         wire logic fast  = control[g*pst_pkg::CTL_STRIDE + pst_pkg::CTL_FAST];
         wire logic accum = control[g*pst_pkg::CTL_STRIDE + pst_pkg::CTL_ACCUM];
         wire logic step  = fast ? fast_pend : slow_pend;
         wire logic [31:0] lim = accum ? pst_pkg::ACCUM_MAX
                                       : (fast ? pst_pkg::SINGLE_MAX : pst_pkg::SINGLE_MAX);

         always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               word[g] <= 32'h0000_0000;
            end else if (wr && hit(avs_address, pst_pkg::REG_WORD_BASE)
                         && sel == IW'(g)) begin
               word[g] <= merge(word[g], avs_writedata, avs_byteenable);
            end else if (scan_req) begin
               if (accum && rst) begin
                  word[g] <= 32'h0000_0000;
               end else if (!accum && !en) begin
                  word[g] <= 32'h0000_0000;
               end else if (en && step && word[g] < lim) begin
                  word[g] <= word[g] + 32'h0000_0001;
               end
               // accumulating, stopped: word held
            end
         end

         // status from value and preset
         assign next_done[g] = (word[g] >= preset_of(g));
      end
   endgenerate

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         timer_done <= '0;
      end else begin
         timer_done <= next_done;
      end
   end

   // ----------------------------------------------------------------
   // interrupt: sticky on done rising, write one clears, set wins
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irq_status <= '0;
      end else begin
         irq_status <= (irq_status
                        & ~((wr && avs_address == pst_pkg::REG_IRQ_STATUS)
                            ? avs_writedata[NUM_TIMERS-1:0] : '0))
                       | (next_done & ~timer_done);
      end
   end

   assign irq = |(irq_status & irq_mask);

   // ----------------------------------------------------------------
   // read path: one wait cycle, then registered data
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         read_done    <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else begin
         read_done <= avs_read && !read_done;
         if (avs_read && !read_done) begin
            if (avs_address == pst_pkg::REG_CONTROL) begin
               avs_readdata <= control;
            end else if (avs_address == pst_pkg::REG_STATUS_BITS) begin
               avs_readdata <= 32'(timer_done);
            end else if (avs_address == pst_pkg::REG_IRQ_STATUS) begin
               avs_readdata <= 32'(irq_status);
            end else if (avs_address == pst_pkg::REG_IRQ_MASK) begin
               avs_readdata <= 32'(irq_mask);
            end else if (hit(avs_address, pst_pkg::REG_PRESET_BASE)) begin
               avs_readdata <= preset[sel];
            end else if (hit(avs_address, pst_pkg::REG_WORD_BASE)
                         || hit(avs_address, pst_pkg::REG_VIEW_BASE)) begin
               avs_readdata <= word[sel];
            end else begin
               avs_readdata <= pst_pkg::READ_UNMAPPED;
            end
         end
      end
   end

   assign avs_waitrequest = avs_read && !read_done;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   // timers that the bench runs accumulating and with a clipped constant
   localparam int ACC_T  = 2;
   localparam int CLIP_T = 4;

   // status bit follows value and preset one register stage later
   chk_done_tracks_value: assert property (@(posedge clock) disable iff (!rst_n)
      $past(rst_n) |-> timer_done[0] == $past(word[0] >= preset_of(0)))
      else $error("status bit disagrees with value and preset");

   // disabled single timer reads zero after a scan
   chk_single_clears: assert property (@(posedge clock) disable iff (!rst_n)
      (scan_req && !control[pst_pkg::CTL_ACCUM] && !control[pst_pkg::CTL_EN]
       && !(wr && avs_address == pst_pkg::REG_WORD_BASE))
      |=> word[0] == 32'h0000_0000)
      else $error("single timer not cleared when disabled");

   // single timer at its top never steps past it
   chk_single_limit: assert property (@(posedge clock) disable iff (!rst_n)
      (scan_req && !control[pst_pkg::CTL_ACCUM] && word[0] >= pst_pkg::SINGLE_MAX
       && avs_address != pst_pkg::REG_WORD_BASE)
      |=> word[0] == $past(word[0]) || word[0] == 32'h0000_0000)
      else $error("single timer passed its limit");

   // stopped accumulating timer keeps its count
   chk_accum_hold: assert property (@(posedge clock) disable iff (!rst_n)
      (scan_req && control[ACC_T*pst_pkg::CTL_STRIDE + pst_pkg::CTL_ACCUM]
       && !control[ACC_T*pst_pkg::CTL_STRIDE + pst_pkg::CTL_EN]
       && !control[ACC_T*pst_pkg::CTL_STRIDE + pst_pkg::CTL_RST])
      |=> $stable(word[ACC_T]))
      else $error("stopped accumulating timer lost its count");

   // reset input clears an accumulating timer on the scan
   chk_accum_reset: assert property (@(posedge clock) disable iff (!rst_n)
      (scan_req && control[ACC_T*pst_pkg::CTL_STRIDE + pst_pkg::CTL_ACCUM]
       && control[ACC_T*pst_pkg::CTL_STRIDE + pst_pkg::CTL_RST])
      |=> word[ACC_T] == 32'h0000_0000)
      else $error("accumulating timer reset did not clear");

   // accumulating count stays inside its range unless software wrote it
   chk_accum_limit: assert property (@(posedge clock) disable iff (!rst_n)
      word[ACC_T] <= pst_pkg::ACCUM_MAX || $past(wr))
      else $error("accumulating timer passed its limit");

   // a one-count step needs a scan with a pending tick
   chk_step_on_tick: assert property (@(posedge clock) disable iff (!rst_n)
      (word[0] == $past(word[0]) + 32'h0000_0001
       && !$past(wr && avs_address != pst_pkg::REG_SCAN))
      |-> $past(scan_req && (fast_pend || slow_pend)))
      else $error("timer stepped without tick and scan");

   // read answered after exactly one wait cycle
   chk_read_answer: assert property (@(posedge clock) disable iff (!rst_n)
      (avs_read && !read_done) |=> !avs_waitrequest)
      else $error("read not answered in one cycle");

   // the 100 ms tick always lands on a 10 ms tick
   chk_slow_on_fast: assert property (@(posedge clock) disable iff (!rst_n)
      slow_tick |-> fast_tick)
      else $error("slow tick off the fast tick grid");

   // fast tick only after a full divider period
   chk_tick_period: assert property (@(posedge clock) disable iff (!rst_n)
      fast_tick |-> $past(fast_cnt) == FAST_TICK_CYC - 1)
      else $error("fast tick before the divider period ended");

   // interrupt flag stays set until a one is written to it
   chk_irq_sticky: assert property (@(posedge clock) disable iff (!rst_n)
      (irq_status[0] && !(wr && avs_address == pst_pkg::REG_IRQ_STATUS && avs_writedata[0]))
      |=> irq_status[0])
      else $error("interrupt flag dropped without a clear");

   // a rising status bit sets its flag, even against a clear
   chk_irq_set_wins: assert property (@(posedge clock) disable iff (!rst_n)
      ($past(rst_n) && next_done[0] && !timer_done[0]) |=> irq_status[0])
      else $error("rising status bit did not set its flag");

   // accumulated view returns the value held in the data word
   chk_view_alias: assert property (@(posedge clock) disable iff (!rst_n)
      (avs_read && !read_done && avs_address == pst_pkg::REG_VIEW_BASE)
      |=> avs_readdata == $past(word[0]))
      else $error("accumulated view differs from data word");

   // a full-lane write lands in the data word of its timer
   chk_word_write: assert property (@(posedge clock) disable iff (!rst_n)
      (wr && avs_address == pst_pkg::REG_WORD_BASE && avs_byteenable == 4'hF)
      |=> word[0] == $past(avs_writedata))
      else $error("data word write did not land");

   // constant preset above range acts as the range top
   chk_const_clip: assert property (@(posedge clock) disable iff (!rst_n)
      (!control[CLIP_T*pst_pkg::CTL_STRIDE + pst_pkg::CTL_ACCUM]
       && !preset[CLIP_T][pst_pkg::PRE_FROM_WORD]
       && (preset[CLIP_T] & pst_pkg::PRE_VALUE_MASK) > pst_pkg::CONST_PRESET_MAX
       && word[CLIP_T] >= pst_pkg::CONST_PRESET_MAX)
      |-> next_done[CLIP_T])
      else $error("constant preset above range not clipped");

   // writes are never held off
   chk_write_no_wait: assert property (@(posedge clock) disable iff (!rst_n)
      avs_write |-> !avs_waitrequest)
      else $error("write held off by waitrequest");

endmodule : pst_timer_unit
`default_nettype wire

// [test/pst_ladder_model.sv]
// Purpose: ladder program side, issues register cycles for the bench
// Assumes: one command at a time, cmd_go held until cmd_done pulses
// Notes:   released address and data lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module pst_ladder_model (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        cmd_go,
   input  wire logic        cmd_wr,
   input  wire logic [11:0] cmd_addr,
   input  wire logic [31:0] cmd_wdata,
   output logic             cmd_done,
   output logic             rd_valid,
   output logic [31:0]      rd_data,
   output logic [11:0]      avs_address,
   output logic             avs_read,
   output logic             avs_write,
   output logic [31:0]      avs_writedata,
   output logic [3:0]       avs_byteenable,
   input  wire logic [31:0] avs_readdata,
   input  wire logic        avs_waitrequest
);
   // request held until waitrequest is seen low at a rising edge
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cmd_done       <= 1'b0;
         rd_valid       <= 1'b0;
         rd_data        <= 32'h0000_0000;
         avs_address    <= 12'h000;
         avs_read       <= 1'b0;
         avs_write      <= 1'b0;
         avs_writedata  <= 32'h0000_0000;
         avs_byteenable <= 4'h0;
      end else begin
         cmd_done <= 1'b0;
         rd_valid <= 1'b0;
         if ((avs_read || avs_write) && !avs_waitrequest) begin
            rd_valid      <= avs_read;
            rd_data       <= avs_readdata;
            cmd_done      <= 1'b1;
            avs_read      <= 1'b0;
            avs_write     <= 1'b0;
            avs_address   <= ~avs_address;   // no stale address
            avs_writedata <= ~avs_writedata; // no stale data
         end else if (cmd_go && !cmd_done && !avs_read && !avs_write) begin
            avs_read       <= !cmd_wr;
            avs_write      <= cmd_wr;
            avs_address    <= cmd_addr;
            avs_writedata  <= cmd_wdata;
            avs_byteenable <= 4'hF;
         end
      end
   end
endmodule : pst_ladder_model
`default_nettype wire

// [test/tb_top.sv]
// Purpose: self-checking bench for the scan timer unit
// Assumes: fast tick shortened to 20 cycles, eight timers
// Notes:   read results are matched against a queue of expected words
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int unsigned NT = 8;
   logic          clock;
   logic          rst_n;
   logic          cmd_go;
   logic          cmd_wr;
   logic [11:0]   cmd_addr;
   logic [31:0]   cmd_wdata;
   logic          cmd_done;
   logic          rd_valid;
   logic [31:0]   rd_data;
   logic [11:0]   avs_address;
   logic          avs_read;
   logic          avs_write;
   logic [31:0]   avs_writedata;
   logic [3:0]    avs_byteenable;
   logic [31:0]   avs_readdata;
   logic          avs_waitrequest;
   logic [NT-1:0] timer_done;
   logic          irq;
   logic [31:0]   exp_q[$];
   string         name_q[$];
   int            n_errors;
   int            checks_done;
   int            seed;
   logic [31:0]   v;

   pst_timer_unit #(.NUM_TIMERS(NT), .FAST_TICK_CYC(20)) pst_timer_unit_inst (
      .clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .timer_done(timer_done), .irq(irq));
   pst_ladder_model pst_ladder_model_inst (
      .clock(clock), .rst_n(rst_n), .cmd_go(cmd_go), .cmd_wr(cmd_wr), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .cmd_done(cmd_done), .rd_valid(rd_valid), .rd_data(rd_data),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

   // 20 MHz clock
   initial clock = 1'b0;
   always #25 clock = ~clock;

   task automatic complete_run();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : complete_run

   task automatic cmp_word(input string what, input logic [31:0] e, input logic [31:0] s);
      checks_done++;
      if (s !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, e, s);
      end
   endtask : cmp_word

   task automatic cmp_bit(input string what, input logic e, input logic s);
      checks_done++;
      if (s !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %b seen %b", what, e, s);
      end
   endtask : cmp_bit

   // one register cycle through the program model, bounded wait
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clock);
      cmd_go    <= 1'b1;
      cmd_wr    <= w;
      cmd_addr  <= a;
      cmd_wdata <= d;
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (cmd_done !== 1'b1 && n < 50);
      if (cmd_done !== 1'b1) begin
         n_errors++;
         complete_run();
      end else begin
         @(posedge clock);
         cmd_go <= 1'b0;
      end
   endtask : bus

   task automatic rd(input logic [11:0] a, input logic [31:0] e, input string what);
      exp_q.push_back(e);
      name_q.push_back(what);
      bus(1'b0, a, 32'h0000_0000);
   endtask : rd

   task automatic scan(input int gap);
      repeat (gap) @(posedge clock);
      bus(1'b1, pst_pkg::REG_SCAN, 32'h0000_0000);
   endtask : scan

   function automatic logic [11:0] wa(input logic [11:0] base, input int i);
      return base + 12'(4 * i);
   endfunction : wa

   // read results taken off the queue as they appear
   always @(negedge clock) begin
      if (rd_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            n_errors++;
            $display("MISMATCH readdata expected none seen %h", rd_data);
         end else begin
            cmp_word(name_q.pop_front(), exp_q.pop_front(), rd_data);
         end
      end
   end

   // main sequence
   initial begin
      seed = 91985;
      rst_n = 1'b0;
      cmd_go = 1'b0;
      cmd_wr = 1'b0;
      cmd_addr = 12'h000;
      cmd_wdata = 32'h0000_0000;
      n_errors = 0;
      checks_done = 0;
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      rd(pst_pkg::REG_CONTROL, 32'h0000_0000, "control");
      rd(pst_pkg::REG_IRQ_MASK, 32'h0000_0000, "mask");
      rd(12'h020, 32'h0000_0000, "unmapped");
      bus(1'b1, wa(pst_pkg::REG_WORD_BASE, NT), 32'h0000_0005);
      rd(wa(pst_pkg::REG_WORD_BASE, NT), 32'h0000_0000, "word8");
      // presets: constants, timer 2 from data word 3
      bus(1'b1, pst_pkg::REG_CONTROL, 32'h0000_8000);
      for (int i = 4; i < NT; i++) bus(1'b1, wa(pst_pkg::REG_PRESET_BASE, i), 32'h0000_0001);
      bus(1'b1, wa(pst_pkg::REG_PRESET_BASE, 0), 32'h0000_0003);
      bus(1'b1, wa(pst_pkg::REG_PRESET_BASE, 1), 32'h0000_0002);
      bus(1'b1, wa(pst_pkg::REG_PRESET_BASE, 2), 32'h8300_0000);
      bus(1'b1, wa(pst_pkg::REG_PRESET_BASE, 3), 32'h07FF_FFFF);
      bus(1'b1, wa(pst_pkg::REG_WORD_BASE, 3), 32'h0000_0002);
      // all status bits rose out of reset with value 0 and preset 0
      rd(pst_pkg::REG_IRQ_STATUS, 32'h0000_00FF, "irqstat");
      bus(1'b1, pst_pkg::REG_IRQ_STATUS, 32'h0000_00FF);
      // fast single timer, irq masked
      bus(1'b1, pst_pkg::REG_CONTROL, 32'h0000_8005);
      for (int k = 1; k <= 4; k++) begin
         scan(25);
         rd(wa(pst_pkg::REG_WORD_BASE, 0), 32'(k), "word0");
         rd(wa(pst_pkg::REG_VIEW_BASE, 0), 32'(k), "view0");
         @(negedge clock);
         cmp_bit("done0", k >= 3, timer_done[0]);
         cmp_bit("irq", 1'b0, irq);
      end
      rd(pst_pkg::REG_STATUS_BITS, 32'h0000_0001, "status");
      rd(pst_pkg::REG_IRQ_STATUS, 32'h0000_0001, "irqstat");
      bus(1'b1, pst_pkg::REG_IRQ_MASK, 32'h0000_0001);
      @(negedge clock);
      cmp_bit("irq", 1'b1, irq);
      bus(1'b1, pst_pkg::REG_IRQ_STATUS, 32'h0000_0001);
      rd(pst_pkg::REG_IRQ_STATUS, 32'h0000_0000, "irqstat");
      @(negedge clock);
      cmp_bit("irq", 1'b0, irq);
      // enable off clears the single timer
      bus(1'b1, pst_pkg::REG_CONTROL, 32'h0000_8000);
      scan(0);
      rd(wa(pst_pkg::REG_WORD_BASE, 0), 32'h0000_0000, "word0");
      cmp_bit("done0", 1'b0, timer_done[0]);
      // single timer saturation
      bus(1'b1, pst_pkg::REG_CONTROL, 32'h0000_8005);
      bus(1'b1, wa(pst_pkg::REG_WORD_BASE, 0), 32'h0000_270E);
      for (int k = 0; k < 2; k++) begin
         scan(25);
         rd(wa(pst_pkg::REG_WORD_BASE, 0), 32'h0000_270F, "word0");
      end
      // tenth-second single timer on the slow tick
      bus(1'b1, pst_pkg::REG_CONTROL, 32'h0000_8010);
      for (int k = 1; k <= 2; k++) begin
         scan(205);
         rd(wa(pst_pkg::REG_WORD_BASE, 1), 32'(k), "word1");
         cmp_bit("done1", k >= 2, timer_done[1]);
      end
      // accumulating: run, hold, resume, reset with enable on
      bus(1'b1, pst_pkg::REG_CONTROL, 32'h0000_8D00);
      for (int k = 1; k <= 2; k++) begin
         scan(25);
         rd(wa(pst_pkg::REG_WORD_BASE, 2), 32'(k), "word2");
         cmp_bit("done2", k >= 2, timer_done[2]);
      end
      bus(1'b1, pst_pkg::REG_CONTROL, 32'h0000_8C00);
      scan(25);
      rd(wa(pst_pkg::REG_WORD_BASE, 2), 32'h0000_0002, "word2");
      bus(1'b1, pst_pkg::REG_CONTROL, 32'h0000_8D00);
      scan(25);
      rd(wa(pst_pkg::REG_WORD_BASE, 2), 32'h0000_0003, "word2");
      bus(1'b1, pst_pkg::REG_CONTROL, 32'h0000_8F00);
      scan(25);
      rd(wa(pst_pkg::REG_WORD_BASE, 2), 32'h0000_0000, "word2");
      cmp_bit("done2", 1'b0, timer_done[2]);
      // accumulating saturation
      bus(1'b1, pst_pkg::REG_CONTROL, 32'h0000_8D00);
      bus(1'b1, wa(pst_pkg::REG_WORD_BASE, 2), pst_pkg::ACCUM_MAX - 32'h0000_0001);
      for (int k = 0; k < 2; k++) begin
         scan(25);
         rd(wa(pst_pkg::REG_VIEW_BASE, 2), 32'h05F5_E0FF, "view2");
      end
      // constant preset above range on single timer 4 acts as 9999
      bus(1'b1, wa(pst_pkg::REG_PRESET_BASE, 4), 32'h0001_0000);
      bus(1'b1, wa(pst_pkg::REG_WORD_BASE, 4), 32'h0000_270F);
      @(negedge clock);
      cmp_bit("done4", 1'b1, timer_done[4]);
      // random values through data word and view of timer 3
      for (int k = 0; k < 4; k++) begin
         v = $random(seed) & 32'h03FF_FFFF;
         bus(1'b1, wa(pst_pkg::REG_WORD_BASE, 3), v);
         rd(wa(pst_pkg::REG_WORD_BASE, 3), v, "word3");
         rd(wa(pst_pkg::REG_VIEW_BASE, 3), v, "view3");
      end
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
